// [sdf_device.sv]
/*
  Device end: sinc3/sinc1 decimation of the 1-bit modulator stream, settling
  control, new-result line and the serial slave for configuration and reads.
  Assumes mod_tick pulses once per master clock period, link pins synchronous.
*/
//
// Contract
// - Decimate 1-bit stream with sinc3 or sinc1
// - Sinc3 default; fast bit selects sinc1
// - Sinc1 settles in one word, same notches
// - Leaving fast mode waits three words
// - Bypass bit puts raw bits on output
// - Sinc3 is three cascaded moving sums
// - Decimation factor is modulator over word rate
// - Notches at word rate and its multiples
// - Sinc3 cutoff at 0.262 of notch
// - Sinc3 attenuates over 100dB at notches
// - Rate bits and notch bits set rate
// - Unsynced step settles within four words
// - Synced step settles in exactly three words
// - New-result line low when result ready
// - Host may hold sync during slow reads
// - Command 0x78 reads three bytes, high first
// - Commands 0x10..0x60 write one config byte
// - Host clocks transfers in eight-pulse groups
// - Clock idles high, change fall, capture rise
// - Host may tie data input and output
// - Master select default 1, picks clock rate
// - Prescaler halves master clock when enabled
module sdf_device import sdf_pkg::*; #(
  parameter int LG_N_MAX = LG_MAX
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                mod_tick,
  input  wire logic                mod_bit,
  output      logic [WORD_W-1:0]   result_word,
  output      logic                result_strobe,
  sdf_link_if.dev                  link
);
  localparam int AW = 3 * LG_N_MAX + 1;

  if (LG_N_MAX < 13) begin : g_chk
    $error("LG_N_MAX too small for the rate selections");
  end

  typedef enum logic [2:0] {
    SDF_L_CMD  = 3'b001,
    SDF_L_DATA = 3'b010,
    SDF_L_READ = 3'b100
  } sdf_lstate_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Log2 of the decimation factor from the rate fields
  function automatic logic [3:0] lg_of(input logic [7:0] c);
    lg_of = LG_BASE + {3'h0, c[F_MCLK]} + {2'h0, c[F_MFH], c[F_MFL]}
          + {2'h0, c[F_NSH], c[F_NSL]};
  endfunction

  // Scale a sum by 2^-sh into a 24-bit word, saturating full scale
  function automatic logic [WORD_W-1:0] norm(input logic [AW-1:0] v, input logic [5:0] sh);
    logic [AW+WORD_W-1:0] w;
    w = {v, {WORD_W{1'b0}}} >> sh;
    norm = (|w[AW+WORD_W-1:WORD_W]) ? {WORD_W{1'b1}} : w[WORD_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Serial slave front end
  // ----------------------------------------------------------------
  logic              sclk_q;
  logic [6:0]        rx_sr;
  logic [2:0]        bit_cnt;
  logic [1:0]        rd_cnt;
  logic [2:0]        reg_sel;
  logic [WORD_W-1:0] tx_sr;
  logic [WORD_W-1:0] data_reg;
  logic [7:0]        cfg [NUM_CFG];
  sdf_lstate_t       lstate;
  logic              rise;
  logic              fall;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic              cfg_wr;
  logic              read_done;

  assign rise      = link.sclk & ~sclk_q;
  assign fall      = ~link.sclk & sclk_q;
  assign byte_done = rise & (bit_cnt == 3'h7);
  assign rx_byte   = {rx_sr, link.sdi};
  assign cfg_wr    = byte_done & (lstate == SDF_L_DATA);
  assign read_done = byte_done & (lstate == SDF_L_READ) & (rd_cnt == 2'h2);

  // Edge detect and MSB-first shift on rising clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclk_q  <= 1'b1;
      rx_sr   <= 7'h0;
      bit_cnt <= 3'h0;
    end else begin
      sclk_q <= link.sclk;
      if (rise) begin
        rx_sr   <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // Command decoding: one command byte, then data or result bytes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lstate  <= SDF_L_CMD;
      rd_cnt  <= 2'h0;
      reg_sel <= 3'h0;
    end else if (byte_done) begin
      case (lstate)
        SDF_L_CMD: begin
          if (rx_byte == CMD_RD_DATA) begin
            lstate <= SDF_L_READ;
            rd_cnt <= 2'h0;
          end else if (rx_byte >= CMD_WR_FIRST && rx_byte <= CMD_WR_LAST
                       && rx_byte[3:0] == CMD_WR_LOW) begin
            reg_sel <= rx_byte[6:4] - 3'h1;
            lstate  <= SDF_L_DATA;
          end
        end
        SDF_L_DATA: lstate <= SDF_L_CMD;
        SDF_L_READ: begin
          rd_cnt <= rd_cnt + 2'h1;
          if (rd_cnt == 2'h2) begin
            lstate <= SDF_L_CMD;
          end
        end
        default: lstate <= SDF_L_CMD;
      endcase
    end
  end

  // Configuration bytes, one data byte per write command
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i] <= (i == 0) ? CFG0_RST : CFG_RST;
      end
    end else if (cfg_wr) begin
      cfg[reg_sel] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Filter control
  // ----------------------------------------------------------------
  logic       fast;
  logic       bypass;
  logic       hold;
  logic       restart;
  logic [3:0] lg;
  logic       pre_ph;
  logic       samp;

  assign fast   = cfg[1][F_FAST];
  assign bypass = cfg[1][F_BYP];
  assign hold   = cfg[1][F_SYNC];
  assign lg     = lg_of(cfg[0]);
  // Any change of rate or of filter mode, and sync hold, flush the filter
  assign restart = hold | (cfg_wr & (reg_sel <= 3'h1));

  // Divide-by-two prescaler keeps an even internal sample cadence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pre_ph <= 1'b0;
    end else if (mod_tick) begin
      pre_ph <= ~pre_ph;
    end
  end
  assign samp = mod_tick & (~cfg[0][F_PRE] | pre_ph);

  // ----------------------------------------------------------------
  // Decimator datapath
  // ----------------------------------------------------------------
  logic [LG_N_MAX-1:0] dec_cnt;
  logic [LG_N_MAX-1:0] n_m1;
  logic                last;
  logic [AW-1:0]       i1, i2, i3, d1, d2, d3;
  logic [AW-1:0]       next_i1, next_i2, next_i3;
  logic [AW-1:0]       c1, c2, c3;
  logic [AW-1:0]       x;
  logic [AW-1:0]       s1;
  logic [1:0]          word_cnt;
  logic [1:0]          need;

  assign x    = {{(AW-1){1'b0}}, mod_bit};
  assign n_m1 = LG_N_MAX'((1 << lg) - 1);
  assign last = samp & (dec_cnt == n_m1);
  assign need = fast ? SETTLE_SINC1 : SETTLE_SINC3;

  // Integrator sums include the current bit, so the third word after a
  // restart already spans 3N samples and is fully settled
  // Comb stage: differences over one word period set nulls at the word rate
  always_comb begin
    next_i1 = i1 + x;
    next_i2 = i2 + next_i1;
    next_i3 = i3 + next_i2;
    c1 = next_i3 - d1;
    c2 = c1 - d2;
    c3 = c2 - d3;
  end

  // One word per N samples; counter restarts with the filter
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      dec_cnt <= '0;
    end else if (samp) begin
      dec_cnt <= last ? '0 : dec_cnt + 1'b1;
    end
  end

  // Three cascaded integrators; sinc1 uses a plain per-word sum
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      i1 <= '0;
      i2 <= '0;
      i3 <= '0;
      s1 <= '0;
    end else if (samp) begin
      i1 <= next_i1;
      i2 <= next_i2;
      i3 <= next_i3;
      s1 <= last ? '0 : s1 + x;
    end
  end

  // Comb delays advance once per output word
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      d1 <= '0;
      d2 <= '0;
      d3 <= '0;
    end else if (last) begin
      d1 <= next_i3;
      d2 <= c1;
      d3 <= c2;
    end
  end

  // Settling: words since restart gate publication of results
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      word_cnt <= 2'h0;
    end else if (last && word_cnt != 2'h3) begin
      word_cnt <= word_cnt + 2'h1;
    end
  end

  // Result register, user strobe and new-result line
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_reg          <= '0;
      result_word       <= '0;
      result_strobe     <= 1'b0;
      link.new_result_n <= 1'b1;
    end else begin
      result_strobe <= 1'b0;
      // Widened sum: a saturated count of 3 must not wrap to 0 and stop results
      if (last && !restart && ({1'b0, word_cnt} + 3'h1 >= {1'b0, need})) begin
        data_reg          <= fast ? norm(s1 + x, {2'h0, lg}) : norm(c3, 6'(3 * lg));
        result_word       <= fast ? norm(s1 + x, {2'h0, lg}) : norm(c3, 6'(3 * lg));
        result_strobe     <= 1'b1;
        link.new_result_n <= 1'b0;
      end else if (restart || read_done) begin
        link.new_result_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output: result bytes, raw bypass stream, else idle high
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_sr    <= '0;
      link.sdo <= 1'b1;
    end else if (byte_done && lstate == SDF_L_CMD && rx_byte == CMD_RD_DATA) begin
      tx_sr <= data_reg;
    end else if (lstate == SDF_L_READ) begin
      if (fall) begin
        link.sdo <= tx_sr[WORD_W-1];
        tx_sr    <= {tx_sr[WORD_W-2:0], 1'b0};
      end
    end else if (bypass) begin
      if (samp) begin
        link.sdo <= mod_bit;
      end
    end else begin
      link.sdo <= 1'b1;
    end
  end
endmodule

// [sdf_host.sv]
/*
  Host end: serial master that writes configuration bytes and reads the
  three-byte result, steered through a small register port.
  Assumes one core clock shared with the device; link inputs synchronous.
*/
module sdf_host import sdf_pkg::*; #(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata,
  sdf_link_if.host         link
);
  // Device answers a falling edge one cycle later; a shorter phase misreads
  if (HALF_CYC < 2) begin : g_chk
    $error("HALF_CYC must be at least 2");
  end

  typedef enum logic [2:0] {
    SDF_H_IDLE = 3'b001,
    SDF_H_LOW  = 3'b010,
    SDF_H_HIGH = 3'b100
  } sdf_hstate_t;

  sdf_hstate_t       hstate;
  logic [15:0]       timer;
  logic [31:0]       tx_sr;
  logic [WORD_W-1:0] rx_sr;
  logic [5:0]        nbits;
  logic [5:0]        bit_cnt;
  logic              is_read;
  logic [WORD_W-1:0] result;
  logic              done;
  logic              start;
  logic [2:0]        idx;
  logic              tmo;
  logic              fin;

  assign idx   = reg_wdata[10:8];
  assign start = reg_wr && reg_addr == H_CTRL && hstate == SDF_H_IDLE && idx != 3'h0;
  assign tmo   = timer == 16'h0;
  assign fin   = hstate == SDF_H_HIGH && tmo && bit_cnt == nbits;

  // ----------------------------------------------------------------
  // Serial master
  // ----------------------------------------------------------------
  // Frames are whole bytes: 2 for a write, 4 for a read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hstate    <= SDF_H_IDLE;
      timer     <= 16'h0;
      tx_sr     <= '0;
      rx_sr     <= '0;
      nbits     <= 6'h0;
      bit_cnt   <= 6'h0;
      is_read   <= 1'b0;
      link.sclk <= 1'b1;
      link.sdi  <= 1'b1;
    end else begin
      case (hstate)
        SDF_H_IDLE: begin
          if (start) begin
            if (idx == IDX_READ) begin
              tx_sr   <= {CMD_RD_DATA, {3{IDLE_FILL}}};
              nbits   <= 6'd32;
              is_read <= 1'b1;
            end else begin
              tx_sr   <= {1'b0, idx, CMD_WR_LOW, reg_wdata[7:0], 16'hffff};
              nbits   <= 6'd16;
              is_read <= 1'b0;
            end
            bit_cnt <= 6'h0;
            timer   <= 16'h0;
            hstate  <= SDF_H_HIGH;
          end
        end
        SDF_H_LOW: begin
          if (tmo) begin
            link.sclk <= 1'b1;
            rx_sr     <= {rx_sr[WORD_W-2:0], link.sdo};
            bit_cnt   <= bit_cnt + 6'h1;
            timer     <= 16'(HALF_CYC - 1);
            hstate    <= SDF_H_HIGH;
          end else begin
            timer <= timer - 16'h1;
          end
        end
        SDF_H_HIGH: begin
          if (tmo) begin
            if (bit_cnt == nbits) begin
              hstate   <= SDF_H_IDLE;
              link.sdi <= 1'b1;
            end else begin
              link.sclk <= 1'b0;
              link.sdi  <= tx_sr[31];
              tx_sr     <= {tx_sr[30:0], 1'b1};
              timer     <= 16'(HALF_CYC - 1);
              hstate    <= SDF_H_LOW;
            end
          end else begin
            timer <= timer - 16'h1;
          end
        end
        default: hstate <= SDF_H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result and completion flag
  // ----------------------------------------------------------------
  // Completion wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result <= '0;
      done   <= 1'b0;
    end else if (fin) begin
      done <= 1'b1;
      if (is_read) begin
        result <= rx_sr;
      end
    end else if (reg_rd && reg_addr == H_RES) begin
      done <= 1'b0;
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == H_STAT) begin
        reg_rdata <= 32'({done, ~link.new_result_n, hstate != SDF_H_IDLE});
      end else if (reg_addr == H_RES) begin
        reg_rdata <= 32'(result);
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

// [sdf_link_checker.sv]
/*
  Checker of the serial link between the filter device and its host.
  Assumes it sits beside the link interface on the shared core clock.
*/
module sdf_link_checker import sdf_pkg::*; #(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic new_result_n
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic       sclk_q;
  logic [7:0] lo_run;
  logic [7:0] hi_run;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt;
  logic [1:0] left;
  logic [3:0] since_byte;
  logic [7:0] cur_byte;
  logic       rise;
  logic       last_bit;
  logic       legal;
  logic       in_read;
  assign rise     = sclk && !sclk_q;
  assign last_bit = rise && bit_cnt == 3'h7;
  assign cur_byte = {shift_q[6:0], sdi};
  assign legal    = cur_byte == CMD_RD_DATA || (cur_byte[3:0] == CMD_WR_LOW &&
                    cur_byte >= CMD_WR_FIRST && cur_byte <= CMD_WR_LAST);

  // Phase lengths; saturating so a long idle never wraps into a false phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b1;
      lo_run <= 8'h00;
      hi_run <= 8'h00;
    end else begin
      sclk_q <= sclk;
      lo_run <= sclk ? 8'h00 : lo_run + {7'h00, lo_run != 8'hff};
      hi_run <= !sclk ? 8'h00 : hi_run + {7'h00, hi_run != 8'hff};
    end
  end

  // Byte decode: command first, then one data byte or three result bytes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_q    <= 8'h00;
      bit_cnt    <= 3'h0;
      left       <= 2'h0;
      since_byte <= 4'hf;
      in_read    <= 1'b0;
    end else begin
      since_byte <= last_bit ? 4'h0 : since_byte + {3'h0, since_byte != 4'hf};
      if (rise) begin
        shift_q <= cur_byte;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (last_bit && left == 2'h0) begin
        left <= (cur_byte == CMD_RD_DATA) ? 2'h3 : {1'b0, legal};
      end else if (last_bit) begin
        left <= left - 2'h1;
      end
      // High while the three result bytes of a read are on the link
      if (last_bit) begin
        in_read <= (left == 2'h0) ? (cur_byte == CMD_RD_DATA) : (left != 2'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rise;
    rise;
  endsequence

  a_reset_idle: assert property (@(posedge core_clk) sys_rst |=> sclk && sdi && sdo && new_result_n)
    else $error("link not idle after reset");
  a_low_half: assert property (@(posedge core_clk) disable iff (sys_rst) s_rise |-> lo_run == 8'(HALF_CYC))
    else $error("serial clock low phase has wrong length");
  a_high_half: assert property (@(posedge core_clk) disable iff (sys_rst) $fell(sclk) |-> hi_run >= 8'(HALF_CYC))
    else $error("serial clock high phase too short");
  a_sdi_capture: assert property (@(posedge core_clk) disable iff (sys_rst) s_rise |-> $stable(sdi))
    else $error("host data moved at capture edge");
  a_sdo_capture: assert property (@(posedge core_clk) disable iff (sys_rst) s_rise |-> $stable(sdo))
    else $error("device data moved at capture edge");
  a_byte_group: assert property (@(posedge core_clk) disable iff (sys_rst)
    hi_run == 8'(4 * HALF_CYC + 4) |-> bit_cnt == 3'h0)
    else $error("idle gap inside a byte");
  a_cmd_legal: assert property (@(posedge core_clk) disable iff (sys_rst) last_bit && left == 2'h0 |-> legal)
    else $error("unknown command byte sent");
  a_result_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(new_result_n) |-> since_byte <= 4'h6)
    else $error("new result line released without a transfer");
  a_line_share: assert property (@(posedge core_clk) disable iff (sys_rst) rise && in_read |-> sdi)
    else $error("host data line not released during result bytes");
endmodule

// [sdf_link_if.sv]
/*
  Three-wire serial link between the filter device and its host, plus the
  active-low new-result line.
  Assumes both ends run on the same core clock.
*/
interface sdf_link_if;
  logic sclk;
  logic sdi;
  logic sdo;
  logic new_result_n;

  modport dev  (input sclk, input sdi, output sdo, output new_result_n);
  modport host (output sclk, output sdi, input sdo, input new_result_n);
endinterface

// [sdf_pkg.sv]
/*
  Shared constants of the sinc decimation filter and its serial host:
  command codes, configuration field positions, reset values, host register
  offsets and serial clock timing.
  Assumes a single 250 MHz core clock on both ends.
*/
package sdf_pkg;
  // ----------------------------------------------------------------
  // Serial commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_FIRST = 8'h10;
  localparam logic [7:0] CMD_WR_LAST  = 8'h60;
  localparam logic [3:0] CMD_WR_LOW   = 4'h0;
  localparam logic [7:0] CMD_RD_DATA  = 8'h78;
  localparam logic [7:0] IDLE_FILL    = 8'hff;
  localparam int         NUM_CFG      = 6;
  localparam int         WORD_W       = 24;

  // ----------------------------------------------------------------
  // Configuration bytes: byte 0 rates, byte 1 filter mode
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG0_RST = 8'h80;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam int F_MCLK = 7;
  localparam int F_PRE  = 6;
  localparam int F_MFH  = 5;
  localparam int F_MFL  = 4;
  localparam int F_NSH  = 1;
  localparam int F_NSL  = 0;
  localparam int F_FAST = 0;
  localparam int F_BYP  = 1;
  localparam int F_SYNC = 2;

  // ----------------------------------------------------------------
  // Decimation and settling
  // ----------------------------------------------------------------
  localparam logic [3:0] LG_BASE      = 4'h6;
  localparam int         LG_MAX       = 13;
  localparam logic [1:0] SETTLE_SINC3 = 2'h3;
  localparam logic [1:0] SETTLE_SINC1 = 2'h1;

  // ----------------------------------------------------------------
  // Host register map and control fields
  // ----------------------------------------------------------------
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_STAT   = 4'h4;
  localparam logic [3:0] H_RES    = 4'h8;
  localparam logic [2:0] IDX_READ = 3'h7;
  localparam int         S_BUSY   = 0;
  localparam int         S_NEW    = 1;
  localparam int         S_DONE   = 2;

  // ----------------------------------------------------------------
  // Serial clock half period, least time rounded up
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int SCLK_HALF_NS  = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
endpackage

// [testbench.sv]
/*
  Testbench: filter device and host joined by the link, driven through the host port.
  Assumes a 250 MHz core clock and a full-scale or zero modulator stream.
*/
module testbench import sdf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 2;
  logic              core_clk  = 1'b0;
  logic              sys_rst   = 1'b1;
  logic              mod_tick  = 1'b0;
  logic              mod_bit   = 1'b1;
  logic [3:0]        reg_addr  = 4'h0;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [31:0]       reg_rdata;
  logic [WORD_W-1:0] result_word;
  logic              result_strobe;
  logic [31:0]       d;
  int                n;
  int                n_errors  = 0;
  int                compares  = 0;
  logic [7:0]        rate_cfg [5] = '{8'h00, 8'h01, 8'h10, 8'h40, 8'h02};
  int                rate_w   [5] = '{128, 256, 256, 256, 512};
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end

  // Tick every other cycle keeps word periods short
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) mod_tick <= ~mod_tick;

  sdf_link_if sdf_link_if_inst ();
  sdf_device sdf_device_inst (.core_clk(core_clk), .sys_rst(sys_rst), .mod_tick(mod_tick),
    .mod_bit(mod_bit), .result_word(result_word), .result_strobe(result_strobe), .link(sdf_link_if_inst.dev));
  sdf_host #(.HALF_CYC(H)) sdf_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(sdf_link_if_inst.host));
  sdf_link_checker #(.HALF_CYC(H)) sdf_link_checker_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .sclk(sdf_link_if_inst.sclk), .sdi(sdf_link_if_inst.sdi), .sdo(sdf_link_if_inst.sdo),
    .new_result_n(sdf_link_if_inst.new_result_n));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ran_out();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // One link transfer, then poll busy under a bound
  task automatic xfer(input logic [2:0] idx, input logic [7:0] v);
    int k;
    k = 0;
    wr(H_CTRL, {21'h0, idx, v});
    do begin
      rd(H_STAT, d);
      k++;
    end while (d[S_BUSY] !== 1'b0 && k < 400);
    if (k >= 400) ran_out();
  endtask
  // Cycles until the next result strobe
  task automatic wait_str(input int lim, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1 c++;
    end while (result_strobe !== 1'b1 && c < lim);
    if (c >= lim) ran_out();
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(H_STAT, d);
    `CHK(d, 32'h0)
    `CHK(sdf_link_if_inst.sclk, 1'b1)
    rd(4'hc, d);
    `CHK(d, 32'h0)
    // Default rate byte gives N = 128, full-scale stream saturates
    wait_str(3000, n);
    `CHK(result_word, 24'hffffff)
    wait_str(600, n);
    `CHK(n, 256)
    `CHK(sdf_link_if_inst.new_result_n, 1'b0)
    xfer(IDX_READ, 8'h00);
    rd(H_RES, d);
    `CHK(d, 32'h00ffffff)
    `CHK(sdf_link_if_inst.new_result_n, 1'b1)
    // Rate fields and prescaler; each write restarts the three-word settling
    foreach (rate_cfg[i]) begin
      xfer(3'h1, rate_cfg[i]);
      `CHK(sdf_link_if_inst.new_result_n, 1'b1)
      wait_str(3000, n);
      `CHK(n >= 3 * rate_w[i] - 12 && n <= 3 * rate_w[i] + 24, 1'b1)
      wait_str(3000, n);
      `CHK(n, rate_w[i])
    end
    // First-order mode settles in one word at the same word rate
    xfer(3'h1, 8'h00);
    xfer(3'h2, 8'h01);
    wait_str(3000, n);
    `CHK(n >= 116 && n <= 152, 1'b1)
    `CHK(result_word, 24'hffffff)
    wait_str(600, n);
    `CHK(n, 128)
    xfer(3'h2, 8'h00);
    wait_str(3000, n);
    `CHK(n >= 3 * 128 - 12, 1'b1)
    // Zero stream after a restart
    @(posedge core_clk);
    mod_bit <= 1'b0;
    xfer(3'h2, 8'h00);
    wait_str(3000, n);
    `CHK(result_word, 24'h000000)
    rd(H_STAT, d);
    `CHK(d[S_NEW], 1'b1)
    // Sync hold keeps the filter still; release settles in three words
    xfer(3'h2, 8'h04);
    repeat (4 * 128) @(posedge core_clk);
    #1 `CHK(sdf_link_if_inst.new_result_n, 1'b1)
    xfer(3'h2, 8'h00);
    wait_str(3000, n);
    `CHK(n >= 3 * 128 - 12 && n <= 3 * 128 + 24, 1'b1)
    // Bypass puts the raw stream on the device output
    xfer(3'h2, 8'h02);
    repeat (20) @(posedge core_clk);
    #1 `CHK(sdf_link_if_inst.sdo, 1'b0)
    @(posedge core_clk);
    mod_bit <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1 `CHK(sdf_link_if_inst.sdo, 1'b1)
    xfer(3'h2, 8'h00);
    // Every write command in turn
    for (int i = 1; i <= NUM_CFG; i++) begin
      rd(H_RES, d);
      rd(H_STAT, d);
      `CHK(d[S_DONE], 1'b0)
      xfer(3'(i), 8'h00);
      rd(H_STAT, d);
      `CHK(d[S_DONE], 1'b1)
    end
    give_verdict();
  end
endmodule
